/* logic/tpw_ctrl.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module tpw_ctrl
  import tpw_pkg::*;
#(
  parameter int WDT_CYCLES = WDT_PERIOD_CYC,
  parameter int OST_CYCLES = OST_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // register port
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // instruction events from the core
  input  wire tpw_instr_t instr,
  // option fuses
  input  wire logic       watchdog_option_fuse,
  input  wire logic       clock_option_fuse,
  // pins
  input  wire tpw_port_t  port_in,
  output tpw_port_t       port_out,
  output tpw_port_t       port_oe,
  input  wire logic       timer_pin,
  input  wire logic       ext_int_n_pin,
  // pad controls
  output logic      [9:0] pullup_enable,
  output logic            roption_enable,
  // status to the core
  output logic            instr_tick,
  output logic            irq_request,
  output logic            cpu_halt,
  output logic            watchdog_reset
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [27:0]      sync1;
  logic [27:0]      sync2;
  logic [2:0][7:0]  pins;
  logic             tmr_pin_s;
  logic             int_pin_s;
  logic             wdt_fuse_s;
  logic             clk_fuse_s;
  logic             tmr_prev;
  logic             int_prev;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // reset to idle pin levels so no false falling edge follows reset
      sync1 <= RST_SYNC;
      sync2 <= RST_SYNC;
    end else begin
      sync1 <= {port_in, timer_pin, ext_int_n_pin,
                watchdog_option_fuse, clock_option_fuse};
      sync2 <= sync1;
    end
  end

  assign pins       = sync2[27:4];
  assign tmr_pin_s  = sync2[3];
  assign int_pin_s  = sync2[2];
  assign wdt_fuse_s = sync2[1];
  assign clk_fuse_s = sync2[0];

  // edge history is taken only from the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tmr_prev <= 1'b0;
      int_prev <= 1'b1;
    end else begin
      tmr_prev <= tmr_pin_s;
      int_prev <= int_pin_s;
    end
  end

  // ----------------------------------------------------------------
  // registers and shared decode
  // ----------------------------------------------------------------
  logic [7:0]       timer_prescale_control;
  logic [7:0]       swc;
  logic [7:0]       p6wake;
  logic [7:0]       imask;
  logic [7:0]       flags;
  logic [7:0]       timer_count;
  logic [7:0]       prescaler;
  logic [2:0][7:0]  dir;
  logic [2:0][7:0]  data;
  tpw_pstate_t      pstate;
  logic [CNT_W-1:0] wdt_base;
  logic [CNT_W-1:0] ost_cnt;
  logic [1:0]       iclk_cnt;

  function automatic logic wr_at(input logic [6:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // ratio mask: prescaler low bits that must all be set to pass one event
  function automatic logic [7:0] ratio_mask(input logic [2:0] r,
                                            input logic       wdt);
    logic [8:0] m;
    m = wdt ? (9'h001 << r) : (9'h002 << r);
    return 8'(m - 9'h001);
  endfunction

  // ----------------------------------------------------------------
  // instruction clock
  // ----------------------------------------------------------------
  logic [1:0] iclk_last;
  assign iclk_last = clk_fuse_s ? ICLK_DIV4_LAST : ICLK_DIV2_LAST;

  // the oscillator is stopped in either sleep, so the cycle stalls
  always_ff @(posedge clk) begin
    if (sys_rst || pstate != PS_RUN) begin
      iclk_cnt <= 2'h0;
    end else if (iclk_cnt == iclk_last) begin
      iclk_cnt <= 2'h0;
    end else begin
      iclk_cnt <= iclk_cnt + 2'h1;
    end
  end

  assign instr_tick = (pstate == PS_RUN) && (iclk_cnt == iclk_last);

  // ----------------------------------------------------------------
  // timer source, prescaler, watchdog
  // ----------------------------------------------------------------
  logic owner_wdt;
  logic ext_edge;
  logic src_evt;
  logic wdt_on;
  logic wdt_clr;
  logic wdt_base_tick;
  logic presc_in;
  logic presc_out;
  logic timer_evt;
  logic wdt_evt;
  logic timer_wr;
  logic overflow;

  assign owner_wdt = timer_prescale_control[TIMER_PRESCALE_CONTROL_OWNER];
  assign ext_edge  = timer_prescale_control[TIMER_PRESCALE_CONTROL_EDGE] ? (tmr_prev && !tmr_pin_s)
                                     : (!tmr_prev && tmr_pin_s);
  assign src_evt   = timer_prescale_control[TIMER_PRESCALE_CONTROL_SRC] ? ext_edge : instr_tick;
  assign wdt_on    = !wdt_fuse_s && swc[SWC_WATCHDOG_ENABLE];
  assign wdt_clr   = instr.watchdog_clear_instr || instr.sleep_instr;
  assign wdt_base_tick = wdt_on &&
                         (wdt_base == CNT_W'(WDT_CYCLES - 1));
  assign presc_in  = owner_wdt ? wdt_base_tick : src_evt;
  assign presc_out = presc_in && ((prescaler & ratio_mask(timer_prescale_control[2:0],
                     owner_wdt)) == ratio_mask(timer_prescale_control[2:0], owner_wdt));
  assign timer_evt = owner_wdt ? src_evt : presc_out;
  assign wdt_evt   = owner_wdt ? presc_out : wdt_base_tick;
  assign timer_wr  = wr_at(ADDR_TIMER);
  assign overflow  = timer_evt && !timer_wr && (timer_count == 8'hff);

  // watchdog base counts on every edge, sleep included
  always_ff @(posedge clk) begin
    if (sys_rst || !wdt_on || wdt_clr || wdt_base_tick) begin
      wdt_base <= '0;
    end else begin
      wdt_base <= wdt_base + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prescaler <= 8'h00;
    end else if ((timer_wr && !owner_wdt) ||
                 (owner_wdt && wdt_clr)) begin
      prescaler <= 8'h00;
    end else if (presc_in) begin
      prescaler <= prescaler + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_count <= 8'h00;
    end else if (timer_wr) begin
      timer_count <= reg_wdata;
    end else if (timer_evt) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wdt_on && wdt_evt && !wdt_clr;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags, mask and global enable
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_view;

  always_comb begin
    flag_set = 8'h00;
    flag_set[IRQ_TMR] = overflow;
    flag_set[IRQ_EXT] = int_prev && !int_pin_s;
  end

  assign flag_view = flags & imask;

  // software writes zero to clear; a new event in that cycle still lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= RST_FLAGS;
    end else if (wr_at(ADDR_IRQ_FLAG)) begin
      flags <= ((flags & reg_wdata) | flag_set) & IRQ_USED;
    end else begin
      flags <= flags | flag_set;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      imask <= RST_IMASK;
    end else if (wr_at(ADDR_IMASK)) begin
      imask <= reg_wdata & IRQ_USED;
    end
  end

  // bit 6 is owned by the instruction events, not by register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_prescale_control <= RST_TIMER_PRESCALE_CONTROL;
    end else begin
      if (wr_at(ADDR_TIMER_PRESCALE_CONTROL)) begin
        timer_prescale_control <= reg_wdata;
      end
      if (instr.irq_disable_instr || instr.irq_ack) begin
        timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE] <= 1'b0;
      end else if (instr.irq_enable_instr || instr.irq_return_instr) begin
        timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE] <= 1'b1;
      end else begin
        timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE] <= timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE] && (|flag_view);
    end
  end

  // ----------------------------------------------------------------
  // sleep control and oscillator start-up
  // ----------------------------------------------------------------
  logic wake_req;

  assign wake_req = (|(~pins[1] & ~p6wake)) ||
                    (!swc[SWC_P7WAKE_N] && !(&pins[2][5:4]));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p6wake <= RST_P6WAKE;
    end else if (wr_at(ADDR_P6WAKE)) begin
      p6wake <= reg_wdata;
    end
  end

  // a wake in the clearing cycle keeps the oscillator running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      swc <= RST_SWC;
    end else begin
      if (wr_at(ADDR_SWC)) begin
        swc <= reg_wdata & SWC_USED;
      end
      if (wake_req) begin
        swc[SWC_RUN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pstate  <= PS_RUN;
      ost_cnt <= '0;
    end else begin
      case (pstate)
        PS_RUN: begin
          if (instr.sleep_instr) begin
            pstate <= PS_SLEEP1;          // only a reset leaves this one
          end else if (!swc[SWC_RUN]) begin
            pstate <= PS_SLEEP2;
          end
        end
        PS_SLEEP2: begin
          if (swc[SWC_RUN]) begin
            pstate  <= PS_OST;
            ost_cnt <= '0;
          end
        end
        PS_OST: begin
          if (ost_cnt == CNT_W'(OST_CYCLES - 1)) begin
            pstate <= PS_RUN;
          end else begin
            ost_cnt <= ost_cnt + CNT_W'(1);
          end
        end
        PS_SLEEP1: begin
          pstate <= PS_SLEEP1;
        end
        default: begin
          pstate <= PS_RUN;
        end
      endcase
    end
  end

  assign cpu_halt = (pstate != PS_RUN);

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_port
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        dir[i]  <= RST_DIR;
        data[i] <= RST_DATA;
      end else begin
        if (wr_at(ADDR_DIR5 + 7'(i))) begin
          dir[i] <= reg_wdata;
        end
        if (wr_at(ADDR_PORT5 + 7'(i))) begin
          data[i] <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_out       <= '0;
      port_oe        <= '0;
      pullup_enable  <= '0;
      roption_enable <= 1'b0;
    end else begin
      port_out       <= data;
      port_oe        <= ~dir;
      if (swc[SWC_ODE]) begin
        port_out.p7[7:6] <= 2'h0;
        port_oe.p7[7:6]  <= ~dir[2][7:6] & ~data[2][7:6];
      end
      if (swc[SWC_ROC]) begin
        port_oe.p7[1:0] <= 2'h0;
      end
      pullup_enable  <= {10{~timer_prescale_control[TIMER_PRESCALE_CONTROL_PULLUP_N]}};
      roption_enable <= swc[SWC_ROC];
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    case (reg_addr)
      ADDR_TIMER:    next_rdata = timer_count;
      ADDR_IRQ_FLAG: next_rdata = flag_view;
      ADDR_TIMER_PRESCALE_CONTROL:     next_rdata = timer_prescale_control;
      ADDR_PORT5:    next_rdata = pins[0];
      ADDR_PORT5 + 7'h01: next_rdata = pins[1];
      ADDR_PORT5 + 7'h02: next_rdata = pins[2];
      ADDR_DIR5:     next_rdata = dir[0];
      ADDR_DIR5 + 7'h01:  next_rdata = dir[1];
      ADDR_DIR5 + 7'h02:  next_rdata = dir[2];
      ADDR_P6WAKE:   next_rdata = p6wake;
      ADDR_SWC:      next_rdata = swc;
      ADDR_IMASK:    next_rdata = imask;
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_sleep2_entry;
    pstate == PS_RUN && !swc[SWC_RUN] && !instr.sleep_instr;
  endsequence

  sequence s_wake;
    pstate == PS_SLEEP2 ##1 pstate == PS_OST;
  endsequence

  sleep_entry_a: assert property (s_sleep2_entry |=>
    pstate == PS_SLEEP2) else $error("sleep 2 not entered");
  wake_hold_a: assert property (s_wake |-> cpu_halt ##1 cpu_halt)
    else $error("core released before start-up wait");
  gie_clear_a: assert property (instr.irq_disable_instr |=>
    !timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE] ##1 !irq_request)
    else $error("global enable not cleared");
  irq_gate_a: assert property (irq_request |->
    $past(timer_prescale_control[TIMER_PRESCALE_CONTROL_GIE]) && $past(|(flags & imask)))
    else $error("interrupt raised without mask and enable");
  timer_wrap_a: assert property (timer_evt && !timer_wr &&
    timer_count == 8'hff |=> timer_count == 8'h00 && flags[IRQ_TMR])
    else $error("timer wrap or overflow flag wrong");
  presc_clr_a: assert property (timer_wr && !owner_wdt |=>
    prescaler == 8'h00) else $error("prescaler kept on timer write");
  wdt_fuse_a: assert property (wdt_fuse_s |-> ##1 !watchdog_reset)
    else $error("watchdog fired with option fuse set");
  flag_read_a: assert property (reg_rd && reg_addr == ADDR_IRQ_FLAG
    |=> reg_rdata == $past(flags & imask))
    else $error("flag read not masked");
  pullup_a: assert property (wr_at(ADDR_TIMER_PRESCALE_CONTROL) &&
    !reg_wdata[TIMER_PRESCALE_CONTROL_PULLUP_N] |-> ##2 pullup_enable == 10'h3ff)
    else $error("pull-ups not enabled");

endmodule

/* pkg/tpw_pkg.sv */
package tpw_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int WDT_PERIOD_NS  = 18_000_000;
  localparam int OST_PERIOD_NS  = 18_000_000;
  // watchdog period is a longest time, start-up wait a least time
  localparam int WDT_PERIOD_CYC = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OST_PERIOD_CYC = (OST_PERIOD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int CNT_W          = 23;
  localparam logic [1:0] ICLK_DIV2_LAST = 2'h1;
  localparam logic [1:0] ICLK_DIV4_LAST = 2'h3;

  // ----------------------------------------------------------------
  // register map (bit 6 of the address selects the control page)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_TIMER    = 7'h01;
  localparam logic [6:0] ADDR_PORT5    = 7'h05;
  localparam logic [6:0] ADDR_IRQ_FLAG = 7'h3f;
  localparam logic [6:0] ADDR_TIMER_PRESCALE_CONTROL     = 7'h41;
  localparam logic [6:0] ADDR_DIR5     = 7'h45;
  localparam logic [6:0] ADDR_P6WAKE   = 7'h4b;
  localparam logic [6:0] ADDR_SWC      = 7'h4e;
  localparam logic [6:0] ADDR_IMASK    = 7'h4f;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TIMER_PRESCALE_CONTROL    = 8'hbf;
  localparam logic [7:0] RST_DIR     = 8'hff;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [7:0] RST_P6WAKE  = 8'hff;
  localparam logic [7:0] RST_SWC     = 8'h31;
  localparam logic [7:0] RST_IMASK   = 8'h00;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  // synchroniser idle levels: interrupt pin high, watchdog fuse set
  localparam logic [27:0] RST_SYNC   = 28'h0000006;
  localparam logic [7:0] SWC_USED    = 8'h79;
  localparam logic [7:0] IRQ_USED    = 8'h09;
  localparam int TIMER_PRESCALE_CONTROL_PULLUP_N = 7;
  localparam int TIMER_PRESCALE_CONTROL_GIE      = 6;
  localparam int TIMER_PRESCALE_CONTROL_SRC      = 5;
  localparam int TIMER_PRESCALE_CONTROL_EDGE     = 4;
  localparam int TIMER_PRESCALE_CONTROL_OWNER    = 3;
  localparam int SWC_ODE       = 6;
  localparam int SWC_WATCHDOG_ENABLE      = 5;
  localparam int SWC_RUN       = 4;
  localparam int SWC_ROC       = 3;
  localparam int SWC_P7WAKE_N  = 0;
  localparam int IRQ_EXT       = 3;
  localparam int IRQ_TMR       = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] p7;
    logic [7:0] p6;
    logic [7:0] p5;
  } tpw_port_t;

  typedef struct packed {
    logic irq_enable_instr;
    logic irq_disable_instr;
    logic irq_return_instr;
    logic irq_ack;
    logic watchdog_clear_instr;
    logic sleep_instr;
  } tpw_instr_t;

  typedef enum logic [1:0] {PS_RUN, PS_SLEEP2, PS_OST, PS_SLEEP1}
    tpw_pstate_t;

endpackage

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import tpw_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int WDT_C = 20;
  localparam int OST_C = 8;
  logic       clk;
  logic       sys_rst;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  tpw_instr_t instr;
  logic       watchdog_option_fuse;
  logic       clock_option_fuse;
  tpw_port_t  port_in;
  tpw_port_t  port_out;
  tpw_port_t  port_oe;
  logic       timer_pin;
  logic       ext_int_n_pin;
  logic [9:0] pullup_enable;
  logic       roption_enable;
  logic       instr_tick;
  logic       irq_request;
  logic       cpu_halt;
  logic       watchdog_reset;
  logic       rd_d;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  int         num_errors;
  int         check_count;
  int         seed;
  int         n;
  int         m;

  tpw_ctrl #(.WDT_CYCLES(WDT_C), .OST_CYCLES(OST_C)) tpw_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr(instr),
    .watchdog_option_fuse(watchdog_option_fuse),
    .clock_option_fuse(clock_option_fuse), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .timer_pin(timer_pin),
    .ext_int_n_pin(ext_int_n_pin), .pullup_enable(pullup_enable),
    .roption_enable(roption_enable), .instr_tick(instr_tick),
    .irq_request(irq_request), .cpu_halt(cpu_halt),
    .watchdog_reset(watchdog_reset));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // the expected value is noted before the strobe goes out
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask

  task automatic ev(input logic [5:0] b);
    @(posedge clk);
    instr <= tpw_instr_t'(b);
    @(posedge clk);
    instr <= '0;
  endtask

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    @(negedge clk);
    chk(g, e);
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, read monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1)
      chk(reg_rdata, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'heaa1;
    {sys_rst, watchdog_option_fuse} = 2'b11;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {instr, clock_option_fuse, timer_pin} = '0;
    port_in = '1;
    ext_int_n_pin = 1'b1;
    wt(10);
    sys_rst <= 1'b0;
    wt(3);
    rd(ADDR_TIMER_PRESCALE_CONTROL, RST_TIMER_PRESCALE_CONTROL);
    for (int i = 0; i < 3; i++) rd(ADDR_DIR5 + 7'(i), RST_DIR);
    rd(ADDR_P6WAKE, RST_P6WAKE);
    rd(ADDR_SWC, RST_SWC);
    rd(ADDR_IMASK, RST_IMASK);
    // unmask both flags so a false edge after reset would show
    wr(ADDR_IMASK, IRQ_USED);
    rd(ADDR_IRQ_FLAG, RST_FLAGS);
    rd(7'h50, 8'h00);
    v = 8'($random(seed));
    wr(ADDR_P6WAKE, v);
    rd(ADDR_P6WAKE, v);
    wr(ADDR_IMASK, v);
    rd(ADDR_IMASK, v & IRQ_USED);
    wr(ADDR_DIR5 + 7'h1, v);
    rd(ADDR_DIR5 + 7'h1, v);
    // interrupt enable flag is not writable, only the events move it
    wr(ADDR_TIMER_PRESCALE_CONTROL, 8'h7f);
    rd(ADDR_TIMER_PRESCALE_CONTROL, 8'h3f);
    ck(pullup_enable, 10'h3ff);
    for (int i = 0; i < 4; i++) begin
      ev(6'h20 >> i);
      rd(ADDR_TIMER_PRESCALE_CONTROL, (i % 2) ? 8'h3f : 8'h7f);
    end
    wr(ADDR_TIMER_PRESCALE_CONTROL, 8'hbf);
    wr(ADDR_IMASK, 8'h08);
    ext_int_n_pin <= 1'b0;
    wt(8);
    rd(ADDR_IRQ_FLAG, 8'h08);
    ck(irq_request, 1'b0);
    ck(pullup_enable, 10'h000);
    ev(6'h20);
    wt(3);
    ck(irq_request, 1'b1);
    wr(ADDR_IMASK, 8'h00);
    rd(ADDR_IRQ_FLAG, 8'h00);
    wr(ADDR_IRQ_FLAG, 8'h00);
    wr(ADDR_IMASK, 8'h08);
    rd(ADDR_IRQ_FLAG, 8'h00);
    ext_int_n_pin <= 1'b1;
    // rising, falling, then rising through the 1:2 prescaler
    for (int i = 0; i < 3; i++) begin
      timer_pin <= 1'b0;
      wt(6);
      wr(ADDR_TIMER_PRESCALE_CONTROL, (i == 1) ? 8'hb8 : (i == 2) ? 8'ha0 : 8'ha8);
      wr(ADDR_TIMER, 8'h00);
      repeat (3) begin
        timer_pin <= 1'b1;
        wt(4);
        timer_pin <= 1'b0;
        wt(4);
      end
      timer_pin <= 1'b1;
      wt(6);
      rd(ADDR_TIMER, (i == 1) ? 8'h03 : (i == 2) ? 8'h02 : 8'h04);
    end
    wr(ADDR_TIMER_PRESCALE_CONTROL, 8'h88);
    wr(ADDR_IMASK, 8'h01);
    wr(ADDR_TIMER, 8'hf0);
    rd(ADDR_IRQ_FLAG, 8'h00);
    wt(40);
    rd(ADDR_IRQ_FLAG, 8'h01);
    for (int f = 0; f < 2; f++) begin
      clock_option_fuse <= f[0];
      wt(4);
      n = 0;
      repeat (40) begin
        @(negedge clk);
        n += int'(instr_tick === 1'b1);
      end
      chk(n, f ? 10 : 20);
      wt(1);
    end
    clock_option_fuse <= 1'b0;
    wr(ADDR_TIMER_PRESCALE_CONTROL, 8'hbf);
    wr(ADDR_P6WAKE, 8'hfe);
    wr(ADDR_SWC, 8'h01);
    wt(2);
    ck(cpu_halt, 1'b1);
    wt(1);
    port_in.p6[1] <= 1'b0;
    port_in.p7[4] <= 1'b0;
    wt(30);
    ck(cpu_halt, 1'b1);
    wt(1);
    port_in.p6[0] <= 1'b0;
    n = 0;
    while (cpu_halt !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n >= OST_C && n < OST_C + 12, 1);
    wt(1);
    port_in <= '1;
    rd(ADDR_SWC, 8'h11);
    wr(ADDR_DIR5 + 7'h2, 8'h00);
    wr(ADDR_PORT5 + 7'h2, 8'hc0);
    wr(ADDR_SWC, 8'h51);
    wt(3);
    ck(port_oe.p7, 8'h3f);
    wr(ADDR_SWC, 8'h11);
    wt(3);
    ck(port_oe.p7, 8'hff);
    ck(port_out.p7, 8'hc0);
    wr(ADDR_SWC, 8'h19);
    wt(3);
    ck({roption_enable, port_oe.p7}, 9'h1fc);
    // watchdog on, off by bit, off by fuse; ratio 2 means 4 base periods
    wr(ADDR_TIMER_PRESCALE_CONTROL, 8'h8a);
    for (int i = 0; i < 3; i++) begin
      wt(1);
      watchdog_option_fuse <= (i == 2);
      wr(ADDR_SWC, (i == 1) ? 8'h11 : 8'h31);
      ev(6'h02);
      n = 0;
      m = 0;
      repeat (4 * WDT_C + 60) begin
        @(negedge clk);
        if (m == 0) n++;
        if (watchdog_reset === 1'b1) m++;
      end
      chk(i ? (m == 0)
            : (n >= 4 * WDT_C - 4 && n <= 4 * WDT_C + 6), 1);
    end
    end_of_test;
  end
endmodule
